// ### design/rsm_map.svh
// offsets, fields, reset values and timing counts of the switchover monitor
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH
`define RSM_OFF_CTRL 12'h000
`define RSM_OFF_STATUS 12'h004
`define RSM_OFF_GRP_LO 12'h008
`define RSM_OFF_GRP_HI 12'h00C
`define RSM_OFF_WAIT 12'h010
`define RSM_OFF_MEMRNG 12'h014
`define RSM_OFF_IOPID 12'h018
`define RSM_OFF_RETRNG 12'h01C
`define RSM_OFF_WORKRNG 12'h020
`define RSM_OFF_IRQ_ST 12'h024
`define RSM_OFF_IRQ_CLR 12'h028
`define RSM_OFF_IRQ_EN 12'h02C
`define RSM_OFF_LINK 12'h030
`define RSM_OFF_CLIENT 12'h040
`define RSM_CTRL_AUTO 0
`define RSM_CTRL_REDUN 1
`define RSM_CTRL_SERVER 2
`define RSM_CTRL_MONWR 3
`define RSM_ST_HANDOVER 0
`define RSM_ST_CFGERR 1
`define RSM_ST_ARMED 2
`define RSM_IRQ_HANDOVER 0
`define RSM_IRQ_CFGERR 1
`define RSM_IRQ_LINKCHG 2
`define RSM_RST_CTRL 32'h0000_0000
`define RSM_RST_MEMRNG 32'h0000_0001
`define RSM_RST_IOBASES 5'h1F
`define RSM_RST_PID 4'h0
`define RSM_RST_RETRNG 32'h07D0_0000
`define RSM_MEM_MAX_KB 9'h100
`define RSM_PID_MAX 4'h8
`define RSM_PID_LOOPS 8'h20
`define RSM_WORK_OFS 32'h0000_8000
`define RSM_CLK_MHZ 200
`define RSM_CABLE_MS 1000
`define RSM_SERVER_CAP_MS 6000
`define RSM_SERVER_LONG_MS 5000
`define RSM_TICK_CYCLES (`RSM_CLK_MHZ * 1000)
`endif

// ### design/rsm_pkg.sv
// types shared by the switchover monitor
// constants live in rsm_map.svh
package rsm_pkg;
    typedef struct packed {
        logic [15:0] link_up;
        logic [15:0] server_up;
    } rsm_side_s;
    typedef enum logic [3:0] {
        RSM_IDLE = 4'b0001,
        RSM_WAIT = 4'b0010,
        RSM_FIRE = 4'b0100,
        RSM_HOLD = 4'b1000
    } rsm_state_e;
endpackage

// ### design/rsm_monitor.sv
// redundancy switchover monitor: groups, trigger choice, timing, status and mirror config
// assumes module status pins are asynchronous; registers over AXI4-Lite slave
//
// Overview of operation
// - evaluate only with auto switchover and redundancy
// - trigger is cable loss or server loss
// - group qualifies when all master modules lost
// - needs one standby module still connected
// - any qualifying group requests handover
// - cable loss: flag instantly, handover within 1s
// - server loss waits; capped at 5s over 5s
// - per-module client word, bit per connection order
// - per-module link bit, one means cable up
// - memory mirror range 1 to 256 kB steps
// - io mirror bases, default 31, error if few
// - pid mirror blocks up to 8 of 32
// - working range derived from retained range
// - fixed areas always mirrored during redundancy
// - monitor writes go to both cpus
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rsm_map.svh"
module rsm_monitor #(
    parameter int NMOD = 16,
    parameter int NGRP = 8,
    parameter int TICK_CYCLES = `RSM_TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // module status pins, master and standby base
    input wire rsm_pkg::rsm_side_s master_pins,
    input wire rsm_pkg::rsm_side_s standby_pins,
    input wire logic [15:0] client_pins [NMOD],
    input wire logic [4:0] installed_bases,
    // handover and mirror outputs
    output logic handover_req,
    output logic mirror_fixed_areas,
    output logic monitor_write_both,
    output logic irq,
    // axi4-lite write address and data
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import rsm_pkg::*;

    // byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction

    // two-flop synchronisers for the pins
    rsm_side_s ms1_reg, ms2_reg, ss1_reg, ss2_reg;
    logic [15:0] cl1_reg [NMOD];
    logic [15:0] cl2_reg [NMOD];
    logic [4:0] ib1_reg, ib2_reg;
    always_ff @(posedge sys_clk)
    begin
        ms1_reg <= master_pins;
        ms2_reg <= ms1_reg;
        ss1_reg <= standby_pins;
        ss2_reg <= ss1_reg;
        ib1_reg <= installed_bases;
        ib2_reg <= ib1_reg;
        for (int i = 0; i < NMOD; i++)
        begin
            cl1_reg[i] <= client_pins[i];
            cl2_reg[i] <= cl1_reg[i];
        end
    end
    // software-visible configuration
    logic [31:0] ctrl_reg, ctrl_next;
    logic [63:0] grp_reg, grp_next;      // 4 bits per module, bit 3 = module grouped
    logic [31:0] wait_reg, wait_next;    // connection wait in ms
    logic [31:0] mem_reg, mem_next;      // [8:0] start kB, [24:16] end kB
    logic [31:0] iopid_reg, iopid_next;  // [4:0] io bases, [11:8] pid blocks
    logic [31:0] ret_reg, ret_next;      // [15:0] start, [31:16] end word
    logic [2:0] ist_reg, ist_next;
    logic [2:0] ien_reg, ien_next;
    logic [15:0] link_prev_reg, link_prev_next;
    // axi handshake state
    logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
    logic [11:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [3:0] ws_reg, ws_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    // decision state
    rsm_state_e st_reg, st_next;
    logic [31:0] tick_reg, tick_next;
    logic [15:0] ms_reg, ms_next;
    logic req_reg, req_next;
    logic [NGRP-1:0] grp_ok;
    logic any_ok, server_mode, armed, cfg_err, link_chg;
    logic [15:0] master_lost, deadline;
    logic [31:0] work_rng;
    logic irq_reg, fix_reg, both_reg;  // registered outputs
    // group qualification from synchronised status
    always_comb
    begin
        server_mode = ctrl_reg[`RSM_CTRL_SERVER];
        // chosen trigger source per module
        master_lost = server_mode ? ~ms2_reg.server_up : ~ms2_reg.link_up;
        grp_ok = '0;
        for (int g = 0; g < NGRP; g++)
        begin
            logic has_m, all_lost, sb_ok;
            has_m = 1'b0;
            all_lost = 1'b1;
            sb_ok = 1'b0;
            for (int m = 0; m < NMOD; m++)
            begin
                if (grp_reg[m*4+3] && grp_reg[m*4 +: 3] == g[2:0])
                begin
                    has_m = 1'b1;
                    all_lost = all_lost & master_lost[m];
                    sb_ok = sb_ok | (server_mode ? ss2_reg.server_up[m]
                                                 : ss2_reg.link_up[m]);
                end
            end
            grp_ok[g] = has_m & all_lost & sb_ok;
        end
        any_ok = |grp_ok;
        armed = ctrl_reg[`RSM_CTRL_AUTO] & ctrl_reg[`RSM_CTRL_REDUN];
        // io bases below installed count is a config error
        cfg_err = iopid_reg[4:0] < ib2_reg;
        link_chg = ms2_reg.link_up != link_prev_reg;
        // cable: act at once, well inside 1 s; server: wait, capped at 5 s
        if (!server_mode)
            deadline = 16'd0;
        else if (wait_reg > `RSM_SERVER_LONG_MS)
            deadline = 16'(`RSM_SERVER_CAP_MS - 1000);
        else
            deadline = wait_reg[15:0];
        // working range sits a fixed distance above the retained range
        work_rng = {ret_reg[31:16] + 16'(`RSM_WORK_OFS), ret_reg[15:0] + 16'(`RSM_WORK_OFS)};
    end
    // handover state machine, one request per event
    always_comb
    begin
        st_next = st_reg;
        tick_next = tick_reg;
        ms_next = ms_reg;
        req_next = 1'b0;
        case (st_reg)
            RSM_IDLE:
            begin
                tick_next = 32'd0;
                ms_next = 16'd0;
                if (armed && any_ok)
                    st_next = RSM_WAIT;
            end
            RSM_WAIT:
            begin
                // condition cleared or disarmed: drop back
                if (!armed || !any_ok)
                    st_next = RSM_IDLE;
                else if (ms_reg >= deadline)
                    st_next = RSM_FIRE;
                else if (tick_reg == 32'(TICK_CYCLES - 1))
                begin
                    tick_next = 32'd0;
                    ms_next = ms_reg + 16'd1;
                end
                else
                    tick_next = tick_reg + 32'd1;
            end
            RSM_FIRE:
            begin
                req_next = 1'b1;
                st_next = RSM_HOLD;
            end
            RSM_HOLD:
            begin
                // rearm once the condition clears
                if (!any_ok || !armed)
                    st_next = RSM_IDLE;
            end
            default:
                st_next = RSM_IDLE;
        endcase
    end
    // bus slave and register writes
    always_comb
    begin
        logic [31:0] nv;
        nv = 32'h0000_0000;
        aw_next = aw_reg;
        w_next = w_reg;
        b_next = b_reg;
        r_next = r_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        rd_next = rd_reg;
        bresp_next = bresp_reg;
        rresp_next = rresp_reg;
        ctrl_next = ctrl_reg;
        grp_next = grp_reg;
        wait_next = wait_reg;
        mem_next = mem_reg;
        iopid_next = iopid_reg;
        ret_next = ret_reg;
        ien_next = ien_reg;
        link_prev_next = ms2_reg.link_up;
        // sticky events, set wins over clear
        ist_next = ist_reg;
        if (s_awvalid && !aw_reg && !b_reg)
        begin
            aw_next = 1'b1;
            awa_next = s_awaddr;
        end
        if (s_wvalid && !w_reg && !b_reg)
        begin
            w_next = 1'b1;
            wd_next = s_wdata;
            ws_next = s_wstrb;
        end
        if (aw_reg && w_reg)
        begin
            aw_next = 1'b0;
            w_next = 1'b0;
            b_next = 1'b1;
            bresp_next = 2'b00;
            case (awa_reg)
                `RSM_OFF_CTRL: ctrl_next = wmerge(ctrl_reg, wd_reg, ws_reg);
                `RSM_OFF_GRP_LO: grp_next[31:0] = wmerge(grp_reg[31:0], wd_reg, ws_reg);
                `RSM_OFF_GRP_HI: grp_next[63:32] = wmerge(grp_reg[63:32], wd_reg, ws_reg);
                `RSM_OFF_WAIT: wait_next = wmerge(wait_reg, wd_reg, ws_reg);
                `RSM_OFF_MEMRNG:
                begin
                    nv = wmerge(mem_reg, wd_reg, ws_reg);
                    // range limited to 1..256 kB, in whole kB
                    if (nv[8:0] >= 9'd1 && nv[24:16] <= `RSM_MEM_MAX_KB && nv[24:16] >= nv[8:0])
                        mem_next = {7'h00, nv[24:16], 7'h00, nv[8:0]};
                    else
                        bresp_next = 2'b10;
                end
                `RSM_OFF_IOPID:
                begin
                    nv = wmerge(iopid_reg, wd_reg, ws_reg);
                    // pid blocks capped at eight
                    if (nv[11:8] <= `RSM_PID_MAX)
                        iopid_next = {20'h00000, nv[11:8], 3'h0, nv[4:0]};
                    else
                        bresp_next = 2'b10;
                end
                `RSM_OFF_RETRNG: ret_next = wmerge(ret_reg, wd_reg, ws_reg);
                `RSM_OFF_IRQ_CLR: ist_next = ist_reg & ~wd_reg[2:0];
                `RSM_OFF_IRQ_EN: ien_next = wd_reg[2:0];
                default: bresp_next = 2'b10;
            endcase
        end
        if (b_reg && s_bready)
            b_next = 1'b0;
        if (s_arvalid && !r_reg)
        begin
            r_next = 1'b1;
            rresp_next = 2'b00;
            case (s_araddr)
                `RSM_OFF_CTRL: rd_next = ctrl_reg;
                `RSM_OFF_STATUS: rd_next = {29'h0, st_reg == RSM_WAIT, cfg_err, req_reg};
                `RSM_OFF_GRP_LO: rd_next = grp_reg[31:0];
                `RSM_OFF_GRP_HI: rd_next = grp_reg[63:32];
                `RSM_OFF_WAIT: rd_next = wait_reg;
                `RSM_OFF_MEMRNG: rd_next = mem_reg;
                `RSM_OFF_IOPID: rd_next = iopid_reg;
                `RSM_OFF_RETRNG: rd_next = ret_reg;
                `RSM_OFF_WORKRNG: rd_next = work_rng;
                `RSM_OFF_IRQ_ST: rd_next = {29'h0, ist_reg};
                `RSM_OFF_IRQ_EN: rd_next = {29'h0, ien_reg};
                // link bit per module, one = cable up
                `RSM_OFF_LINK: rd_next = {16'h0000, ms2_reg.link_up};
                default:
                begin
                    rd_next = 32'h0000_0000;
                    rresp_next = 2'b10;
                    // client words, bit order = connection order
                    for (int i = 0; i < NMOD; i++)
                    begin
                        if (s_araddr == 12'(`RSM_OFF_CLIENT + 4 * i))
                        begin
                            rd_next = {16'h0000, cl2_reg[i]};
                            rresp_next = 2'b00;
                        end
                    end
                end
            endcase
        end
        if (r_reg && s_rready)
            r_next = 1'b0;
        if (req_reg)
            ist_next[`RSM_IRQ_HANDOVER] = 1'b1;
        if (cfg_err)
            ist_next[`RSM_IRQ_CFGERR] = 1'b1;
        if (link_chg)
            ist_next[`RSM_IRQ_LINKCHG] = 1'b1;
    end
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= RSM_IDLE;
            tick_reg <= 32'd0;
            ms_reg <= 16'd0;
            req_reg <= 1'b0;
            ctrl_reg <= `RSM_RST_CTRL;
            grp_reg <= 64'h0;
            wait_reg <= 32'd0;
            mem_reg <= `RSM_RST_MEMRNG;
            iopid_reg <= {20'h00000, `RSM_RST_PID, 3'h0, `RSM_RST_IOBASES};
            ret_reg <= `RSM_RST_RETRNG;
            ist_reg <= 3'h0;
            ien_reg <= 3'h0;
            link_prev_reg <= 16'h0000;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            b_reg <= 1'b0;
            r_reg <= 1'b0;
            awa_reg <= 12'h000;
            wd_reg <= 32'h0;
            ws_reg <= 4'h0;
            rd_reg <= 32'h0;
            bresp_reg <= 2'b00;
            rresp_reg <= 2'b00;
            irq_reg <= 1'b0;
            fix_reg <= 1'b0;
            both_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            tick_reg <= tick_next;
            ms_reg <= ms_next;
            req_reg <= req_next;
            ctrl_reg <= ctrl_next;
            grp_reg <= grp_next;
            wait_reg <= wait_next;
            mem_reg <= mem_next;
            iopid_reg <= iopid_next;
            ret_reg <= ret_next;
            ist_reg <= ist_next;
            ien_reg <= ien_next;
            link_prev_reg <= link_prev_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            b_reg <= b_next;
            r_reg <= r_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            rd_reg <= rd_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            irq_reg <= |(ist_next & ien_next);
            fix_reg <= ctrl_next[`RSM_CTRL_REDUN];
            both_reg <= ctrl_next[`RSM_CTRL_MONWR];
        end
    end

    assign handover_req = req_reg;
    assign mirror_fixed_areas = fix_reg;
    assign monitor_write_both = both_reg;
    assign irq = irq_reg;
    assign s_awready = !aw_reg && !b_reg;
    assign s_wready = !w_reg && !b_reg;
    assign s_bvalid = b_reg;
    assign s_bresp = bresp_reg;
    assign s_arready = !r_reg;
    assign s_rvalid = r_reg;
    assign s_rdata = rd_reg;
    assign s_rresp = rresp_reg;
endmodule

// ### tb/rsm_checker.sv
// checker: bus and handover relations at the monitor ports
// assumes one clock and the synchronous active-high reset of the monitor
`timescale 1ns/1ps
module rsm_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // module status pins
    input wire rsm_pkg::rsm_side_s master_pins,
    input wire rsm_pkg::rsm_side_s standby_pins,
    // decision outputs
    input wire logic handover_req,
    input wire logic mirror_fixed_areas,
    input wire logic monitor_write_both,
    // bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata
);
    import rsm_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // eight cycles cover sync plus fire path
    a_req_single: assert property (handover_req |=> !handover_req)
        else $error("req too long");
    a_master_up: assert property ((master_pins == '1) [*8] |=> !handover_req)
        else $error("req with masters up");
    a_no_standby: assert property ((standby_pins == '0) [*8] |=> !handover_req)
        else $error("req with no standby");
    a_not_redun: assert property (!mirror_fixed_areas [*8] |=> !handover_req)
        else $error("req not redundant");
    a_fixed_write: assert property ($changed(mirror_fixed_areas) |-> $rose(s_bvalid))
        else $error("fixed flag moved");
    a_both_write: assert property ($changed(monitor_write_both) |-> $rose(s_bvalid))
        else $error("both flag moved");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready
        |=> ##1 s_bvalid)
        else $error("write answer late");
endmodule

// ### tb/rsm_far_model.sv
// far side: status pins of master and standby modules
// assumes pins move on the edge after a call
`timescale 1ns/1ps
module rsm_far_model (
    // clock
    input wire logic sys_clk,
    // module status pins
    output rsm_pkg::rsm_side_s master_pins,
    output rsm_pkg::rsm_side_s standby_pins,
    output logic [15:0] client_pins [16]
);
    import rsm_pkg::*;
    // all modules linked and serving, no clients yet
    initial
    begin
        master_pins = '1;
        standby_pins = '1;
        for (int i = 0; i < 16; i++)
            client_pins[i] = 16'h0000;
    end
    // master base link and server state
    task automatic set_master(input logic [15:0] lnk, input logic [15:0] srv);
        @(posedge sys_clk);
        master_pins <= '{link_up: lnk, server_up: srv};
    endtask
    // standby base link and server state
    task automatic set_standby(input logic [15:0] lnk, input logic [15:0] srv);
        @(posedge sys_clk);
        standby_pins <= '{link_up: lnk, server_up: srv};
    endtask
    // client word of one module
    task automatic set_client(input int i, input logic [15:0] w);
        @(posedge sys_clk);
        client_pins[i] <= w;
    endtask
endmodule

// ### tb/tb_top.sv
// testbench for the switchover monitor
// assumes rsm_map.svh on the include path; short ms tick
`timescale 1ns/1ps
`include "rsm_map.svh"
module tb_top;
    import rsm_pkg::*;
    localparam int TICK = 4;
    // one expected bus answer
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rsm_exp_s;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    rsm_side_s master_pins, standby_pins;
    logic [15:0] client_pins [16];
    logic [4:0] installed_bases = 5'h05;
    logic handover_req, mirror_fixed_areas, monitor_write_both, irq;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    rsm_exp_s expq [$];
    logic [15:0] cw [16];
    logic [15:0] lfsr = 16'h3855;
    int miscompares = 0, n_checks = 0, cycles = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    rsm_far_model far (.sys_clk(sys_clk), .master_pins(master_pins),
        .standby_pins(standby_pins), .client_pins(client_pins));
    rsm_monitor #(.TICK_CYCLES(TICK)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .master_pins(master_pins), .standby_pins(standby_pins), .client_pins(client_pins),
        .installed_bases(installed_bases), .handover_req(handover_req),
        .mirror_fixed_areas(mirror_fixed_areas), .monitor_write_both(monitor_write_both),
        .irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready));
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bus write
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, b;
        expq.push_back('{d: 32'h0, m: 32'h0, r: r});
        @(posedge sys_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge sys_clk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            @(posedge sys_clk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (b) s_bready <= 1'b0;
        end
    endtask
    // bus read
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r);
        logic ar, v;
        expq.push_back('{d: d, m: m, r: r});
        @(posedge sys_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        v = 1'b0;
        while (!v)
        begin
            @(negedge sys_clk);
            ar = s_arvalid && s_arready;
            v = s_rvalid;
            @(posedge sys_clk);
            if (ar) s_arvalid <= 1'b0;
            if (v) s_rready <= 1'b0;
        end
    endtask
    // count pulses in hi cycles, none before lo
    task automatic expect_req(input int lo, input int hi, input int n);
        int k, first;
        k = 0;
        first = 0;
        for (int t = 1; t <= hi; t++)
        begin
            @(negedge sys_clk);
            if (handover_req === 1'b1)
            begin
                k++;
                if (first == 0) first = t;
            end
        end
        check(k, n);
        if (n > 0) check(first >= lo, 1);
    endtask
    // scoreboard
    always @(negedge sys_clk)
    begin
        rsm_exp_s e;
        if ((s_rvalid && s_rready) || (s_bvalid && s_bready))
        begin
            e = expq.pop_front();
            if (s_rvalid)
            begin
                check(s_rdata & e.m, e.d & e.m);
                check({30'h0, s_rresp}, {30'h0, e.r});
            end
            else
                check({30'h0, s_bresp}, {30'h0, e.r});
        end
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`RSM_OFF_CTRL, `RSM_RST_CTRL, 32'h0000_000F, 2'b00);
        rd(`RSM_OFF_MEMRNG, 32'h0000_0001, 32'h01FF_01FF, 2'b00);
        rd(`RSM_OFF_IOPID, 32'h0000_001F, 32'h0000_0F1F, 2'b00);
        rd(`RSM_OFF_RETRNG, 32'h07D0_0000, 32'hFFFF_FFFF, 2'b00);
        rd(`RSM_OFF_WORKRNG, 32'h87D0_8000, 32'hFFFF_FFFF, 2'b00);
        rd(12'hFFC, 32'h0, 32'h0, 2'b10);
        wr(12'hFF8, 32'h1234_5678, 2'b10);
        wr(`RSM_OFF_MEMRNG, 32'h0101_0001, 2'b10);
        wr(`RSM_OFF_MEMRNG, 32'h0100_0001, 2'b00);
        rd(`RSM_OFF_MEMRNG, 32'h0100_0001, 32'h01FF_01FF, 2'b00);
        wr(`RSM_OFF_IOPID, 32'h0000_0903, 2'b10);
        wr(`RSM_OFF_IOPID, 32'h0000_0803, 2'b00);
        rd(`RSM_OFF_STATUS, 32'h0000_0002, 32'h0000_0002, 2'b00);
        check({31'h0, irq}, 32'h0);
        wr(`RSM_OFF_IRQ_EN, 32'h0000_0002, 2'b00);
        @(negedge sys_clk);
        check({31'h0, irq}, 32'h1);
        wr(`RSM_OFF_IOPID, 32'h0000_001F, 2'b00);
        wr(`RSM_OFF_IRQ_CLR, 32'h0000_0002, 2'b00);
        @(negedge sys_clk);
        check({31'h0, irq}, 32'h0);
        wr(`RSM_OFF_RETRNG, 32'h0100_0010, 2'b00);
        rd(`RSM_OFF_WORKRNG, 32'h8100_8010, 32'hFFFF_FFFF, 2'b00);
        // random client words and links
        for (int i = 0; i < 16; i++)
        begin
            lfsr = lfsr_next(lfsr);
            cw[i] = lfsr;
            far.set_client(i, lfsr);
        end
        lfsr = lfsr_next(lfsr);
        far.set_master(lfsr, 16'hFFFF);
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 16; i++)
            rd(`RSM_OFF_CLIENT + 12'(4 * i), {16'h0, cw[i]}, 32'h0000_FFFF, 2'b00);
        rd(`RSM_OFF_LINK, {16'h0, lfsr}, 32'h0000_FFFF, 2'b00);
        far.set_master(16'hFFFF, 16'hFFFF);
        // modules 0,1 are group 1; module 2 is group 2
        wr(`RSM_OFF_GRP_LO, 32'h0000_0A99, 2'b00);
        wr(`RSM_OFF_IRQ_EN, 32'h0000_0001, 2'b00);
        wr(`RSM_OFF_CTRL, 32'h0000_0001, 2'b00);
        far.set_master(16'hFFFC, 16'hFFFF);
        expect_req(0, 40, 0);
        far.set_master(16'hFFFF, 16'hFFFF);
        wr(`RSM_OFF_CTRL, 32'h0000_0003, 2'b00);
        check({31'h0, mirror_fixed_areas}, 32'h1);
        far.set_master(16'hFFFE, 16'hFFFF);
        expect_req(0, 40, 0);
        far.set_master(16'hFFFC, 16'hFFFF);
        expect_req(0, 60, 1);
        check({31'h0, irq}, 32'h1);
        wr(`RSM_OFF_IRQ_CLR, 32'h0000_0001, 2'b00);
        @(negedge sys_clk);
        check({31'h0, irq}, 32'h0);
        far.set_master(16'hFFFF, 16'hFFFF);
        far.set_standby(16'h0000, 16'h0000);
        repeat (10) @(posedge sys_clk);
        far.set_master(16'hFFFC, 16'hFFFF);
        expect_req(0, 40, 0);
        far.set_standby(16'hFFFF, 16'hFFFF);
        expect_req(0, 40, 1);
        far.set_master(16'hFFFF, 16'hFFFF);
        repeat (10) @(posedge sys_clk);
        far.set_master(16'hFFFB, 16'hFFFF);
        expect_req(0, 40, 1);
        far.set_master(16'hFFFF, 16'hFFFF);
        // server trigger, short then cancelled wait
        wr(`RSM_OFF_WAIT, 32'h0000_0003, 2'b00);
        wr(`RSM_OFF_CTRL, 32'h0000_000F, 2'b00);
        check({31'h0, monitor_write_both}, 32'h1);
        far.set_master(16'hFFFF, 16'hFFFC);
        expect_req(2 * TICK, 80, 1);
        far.set_master(16'hFFFF, 16'hFFFF);
        repeat (10) @(posedge sys_clk);
        far.set_master(16'hFFFF, 16'hFFFC);
        repeat (2) @(posedge sys_clk);
        far.set_master(16'hFFFF, 16'hFFFF);
        expect_req(0, 80, 0);
        // long wait is capped
        wr(`RSM_OFF_WAIT, 32'd6000, 2'b00);
        far.set_master(16'hFFFF, 16'hFFFC);
        expect_req(4900 * TICK, 5000 * TICK + 60, 1);
        tally_and_finish();
    end
endmodule
bind rsm_monitor rsm_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .master_pins(master_pins), .standby_pins(standby_pins), .handover_req(handover_req),
    .mirror_fixed_areas(mirror_fixed_areas), .monitor_write_both(monitor_write_both),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .s_rdata(s_rdata));
